// ==== inc/port_b_pkg.sv ====
package port_b_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_PORT_DATA = 8'h06;
    localparam logic [7:0] IDX_BIT_OP    = 8'h07;
    localparam logic [7:0] IDX_INT_CTRL  = 8'h0b;
    localparam logic [7:0] IDX_CONFIG    = 8'h81;
    localparam logic [7:0] IDX_DIRECTION = 8'h86;

    localparam logic [7:0] RST_CONFIG    = 8'hff;
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PORT_DATA = 8'h00;

    localparam int PULLUP_DIS_BIT  = 7;
    localparam int CHANGE_FLAG_BIT = 0;
    localparam int BITOP_SET_BIT   = 7;
    localparam int BITOP_SEL_MSB   = 2;
    localparam int EXT_INT_BIT     = 0;
    localparam int PROG_CLOCK_BIT  = 6;
    localparam int PROG_DATA_BIT   = 7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACK  = 2'b10
    } bus_state_t;

    typedef struct packed {
        logic [7:0]  idx;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] pin_i,
    output logic      [7:0] level_o
);
    logic [7:0] meta;
    logic [7:0] stage2;
    logic [7:0] stage3;

    // A change is taken only once the second and third stages agree.
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    meta[i]    <= 1'b0;
                    stage2[i]  <= 1'b0;
                    stage3[i]  <= 1'b0;
                    level_o[i] <= 1'b0;
                end else if (ce_i) begin
                    meta[i]   <= pin_i[i];
                    stage2[i] <= meta[i];
                    stage3[i] <= stage2[i];
                    if (stage2[i] == stage3[i]) begin
                        level_o[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync

// ==== design/change_detect.sv ====
`timescale 1ns/10ps
module change_detect (
    input  wire logic [3:0] level_i,
    input  wire logic [3:0] snap_i,
    input  wire logic [3:0] is_input_i,
    output logic      [3:0] mismatch_o
);
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_pin
            assign mismatch_o[i] = is_input_i[i] & (level_i[i] ^ snap_i[i]);
        end
    endgenerate
endmodule // change_detect

// ==== design/port_b_gpio_change_detect.sv ====
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/10ps
module port_b_gpio_change_detect
    import port_b_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  pullup_en_o,
    output logic             wake_o,
    output logic             ext_interrupt_pin_o,
    output logic             prog_clock_pin_o,
    output logic             prog_data_pin_o
);
    bus_state_t state;
    bus_state_t next_state;
    wb_req_t    req;
    logic [7:0] pin_level;
    logic [7:0] pin_sample;
    logic [7:0] second_port_data;
    logic [7:0] second_port_direction;
    logic [7:0] timer_port_config;
    logic [3:0] snap;
    logic [3:0] mismatch;
    logic       pin_change_flag;

    pin_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .pin_i     (pin_i),
        .level_o   (pin_level)
    );

    change_detect u_change (
        .level_i    (pin_level[7:4]),
        .snap_i     (snap),
        .is_input_i (second_port_direction[7:4]),
        .mismatch_o (mismatch)
    );

    // Bus request and decode.
    assign req = '{idx: wb_adr_i[9:2], we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};

    wire start     = wb_cyc_i & wb_stb_i & (state == ST_IDLE);
    wire in_ack    = (state == ST_ACK);
    wire commit    = in_ack & wb_cyc_i & wb_stb_i & req.we & req.sel[0];
    wire hit_port  = (req.idx == IDX_PORT_DATA);
    wire hit_bitop = (req.idx == IDX_BIT_OP);
    wire hit_int   = (req.idx == IDX_INT_CTRL);
    wire hit_cfg   = (req.idx == IDX_CONFIG);
    wire hit_dir   = (req.idx == IDX_DIRECTION);

    // Both the plain port access and the bit operation touch the port.
    wire port_touch = start & (hit_port | hit_bitop);

    wire [7:0] rd_data = hit_port ? pin_level :
                         hit_int  ? {7'h00, pin_change_flag} :
                         hit_cfg  ? timer_port_config :
                         hit_dir  ? second_port_direction : 8'h00;

    wire [2:0] bit_sel  = req.dat[BITOP_SEL_MSB:0];
    wire [7:0] bit_mask = 8'h01 << bit_sel;
    // The whole sampled byte goes back to the latch, so input pins copy their level.
    wire [7:0] bit_result = req.dat[BITOP_SET_BIT] ? (pin_sample | bit_mask)
                                                   : (pin_sample & ~bit_mask);

    wire [7:0] pullup_next = timer_port_config[PULLUP_DIS_BIT] ? 8'h00
                                                                : second_port_direction;

    wire flag_clear_val = (commit & hit_int) ? req.dat[CHANGE_FLAG_BIT] : pin_change_flag;
    wire next_flag      = (|mismatch) | flag_clear_val;

    always_comb begin
        case (state)
            ST_IDLE: next_state = start ? ST_ACK : ST_IDLE;
            ST_ACK:  next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Bus handshake: ack comes one cycle after the request and lasts one cycle.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state    <= ST_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            state    <= next_state;
            wb_ack_o <= start;
            if (start) begin
                wb_dat_o <= {24'h00_0000, rd_data};
            end
        end
    end

    // Pins are sampled when any access begins; the snapshot only when a port or bit-operation access begins.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_sample <= 8'h00;
            snap       <= 4'h0;
        end else if (ce_i) begin
            if (start) begin
                pin_sample <= pin_level;
            end
            if (port_touch) begin
                snap <= pin_level[7:4];
            end
        end
    end

    // Writes land at the acknowledging edge, which closes the access.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            second_port_data      <= RST_PORT_DATA;
            second_port_direction <= RST_DIRECTION;
            timer_port_config     <= RST_CONFIG;
        end else if (ce_i && commit) begin
            if (hit_port) begin
                second_port_data <= req.dat[7:0];
            end
            if (hit_bitop) begin
                second_port_data <= bit_result;
            end
            if (hit_dir) begin
                second_port_direction <= req.dat[7:0];
            end
            if (hit_cfg) begin
                timer_port_config <= req.dat[7:0];
            end
        end
    end

    // A mismatch is seen every cycle, so a software clear only sticks once no
    // upper input pin differs from the snapshot any more.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_change_flag <= 1'b0;
        end else if (ce_i) begin
            pin_change_flag <= next_flag;
        end
    end

    assign pin_o = second_port_data;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pin_oe_o            <= 8'h00;
            pullup_en_o         <= 8'h00;
            wake_o              <= 1'b0;
            ext_interrupt_pin_o <= 1'b0;
            prog_clock_pin_o    <= 1'b0;
            prog_data_pin_o     <= 1'b0;
        end else if (ce_i) begin
            pin_oe_o            <= ~second_port_direction;
            pullup_en_o         <= pullup_next;
            wake_o              <= pin_change_flag;
            ext_interrupt_pin_o <= pin_level[EXT_INT_BIT];
            prog_clock_pin_o    <= pin_level[PROG_CLOCK_BIT];
            prog_data_pin_o     <= pin_level[PROG_DATA_BIT];
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_port_read;
        ce_i && start && hit_port && !req.we;
    endsequence

    sequence s_answer(logic [7:0] v);
        wb_ack_o && (wb_dat_o == {24'h00_0000, v});
    endsequence

    property p_direction;
        ce_i |=> (pin_oe_o == ~$past(second_port_direction));
    endproperty
    a_direction: assert property (p_direction) else $error("drive enable not from direction");

    property p_pullup;
        ce_i |=> (pullup_en_o == ($past(timer_port_config[PULLUP_DIS_BIT]) ? 8'h00
                                  : $past(second_port_direction)));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

    property p_reset_values;
        disable iff (1'b0)
        sys_rst_i |=> (timer_port_config == 8'hff) && (second_port_direction == 8'hff)
                      && (pullup_en_o == 8'h00);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

    property p_exclude_outputs;
        (mismatch & ~second_port_direction[7:4]) == 4'h0;
    endproperty
    a_exclude_outputs: assert property (p_exclude_outputs) else $error("output pin in compare");

    property p_flag_set;
        ce_i && (|mismatch) |=> pin_change_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");

    property p_snapshot;
        ce_i && port_touch |=> (snap == $past(pin_level[7:4])) && (mismatch == 4'h0 || !ce_i
                                || $changed(pin_level[7:4]) || $changed(second_port_direction));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot not refreshed");

    property p_read_pins;
        logic [7:0] v;
        (s_port_read, v = pin_level) |=> s_answer(v);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("port read not pin levels");

    property p_bit_op;
        ce_i && commit && hit_bitop |=> (second_port_data == $past(bit_result));
    endproperty
    a_bit_op: assert property (p_bit_op) else $error("bit operation result wrong");

    property p_wake;
        ce_i |=> (wake_o == $past(pin_change_flag));
    endproperty
    a_wake: assert property (p_wake) else $error("wake not following flag");

    property p_alt_roles;
        ce_i |=> (ext_interrupt_pin_o == $past(pin_level[EXT_INT_BIT]))
                 && (prog_data_pin_o == $past(pin_level[PROG_DATA_BIT]));
    endproperty
    a_alt_roles: assert property (p_alt_roles) else $error("second role pin wrong");

    property p_prog_clock;
        ce_i |=> (prog_clock_pin_o == $past(pin_level[PROG_CLOCK_BIT]));
    endproperty
    a_prog_clock: assert property (p_prog_clock) else $error("prog clock wrong");

    sequence s_flag_clear;
        ce_i && commit && hit_int && !req.dat[CHANGE_FLAG_BIT];
    endsequence

    // The clear only sticks while no upper input pin differs from the snapshot.
    property p_flag_clear;
        s_flag_clear ##0 (mismatch == 4'h0) |=> !pin_change_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

    property p_ack_pulse;
        ce_i && wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

    property p_ack_follows;
        ce_i && start |=> wb_ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("access not answered");

    property p_port_write;
        ce_i && commit && hit_port |=> (second_port_data == $past(req.dat[7:0]));
    endproperty
    a_port_write: assert property (p_port_write) else $error("port write not latched");

    property p_dir_write;
        ce_i && commit && hit_dir |=> (second_port_direction == $past(req.dat[7:0]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_cfg_write;
        ce_i && commit && hit_cfg |=> (timer_port_config == $past(req.dat[7:0]));
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_read_flag;
        ce_i && start && hit_int && !req.we
            |=> (wb_dat_o == {31'h0000_0000, $past(pin_change_flag)});
    endproperty
    a_read_flag: assert property (p_read_flag) else $error("flag read wrong");

endmodule // port_b_gpio_change_detect

// ==== verif/pin_model.sv ====
`timescale 1ns/10ps
module pin_model (
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] pullup_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] level_o
);
    logic [7:0] last = 8'h00;

    // An undriven pin with no pull-up keeps flipping, so a floating pin can never pass for a value.
    // Outside loads only reach pins that the port leaves as inputs, so no two drivers fight.
    assign level_o = (oe_i & drive_i) | (~oe_i & ext_en_i & ext_val_i)
                   | (~oe_i & ~ext_en_i & (pullup_i | ~last));

    always_ff @(posedge sys_clk_i) begin
        last <= level_o;
    end
endmodule // pin_model

// ==== verif/port_b_gpio_change_detect_tb.sv ====
`timescale 1ns/10ps
module port_b_gpio_change_detect_tb;
    import port_b_pkg::*;
    logic        sys_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, wake;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [7:0]  pin_o, oe, pu, lvl, q, v, dir, lat, e;
    logic [7:0]  ext_v = 8'h00, ext_en = 8'hff;
    logic        xint, pclk, pdat;
    int          error_cnt = 0, n_checks = 0, cycles = 0, n;

    always #50 sys_clk_i = ~sys_clk_i;

    port_b_gpio_change_detect uut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(lvl), .pin_o(pin_o),
        .pin_oe_o(oe), .pullup_en_o(pu), .wake_o(wake), .ext_interrupt_pin_o(xint),
        .prog_clock_pin_o(pclk), .prog_data_pin_o(pdat));

    pin_model pins (.sys_clk_i(sys_clk_i), .drive_i(pin_o), .oe_i(oe), .pullup_i(pu),
        .ext_val_i(ext_v), .ext_en_i(ext_en), .level_o(lvl));

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The answer is taken at the edge where ack is seen high, before that edge's updates land.
    // Only the bench timeout ends a wait for an answer that never comes.
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge sys_clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h0, d};
        do begin
            @(posedge sys_clk_i);
        end while (ack !== 1'b1);
        chk(rdat[15:8], 8'h00, "upper read bits");
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask

    task automatic wait_cyc(input int c);
        repeat (c) @(posedge sys_clk_i);
    endtask

    function automatic logic [7:0] exp_pins(input logic [7:0] d, l, x);
        return (l & ~d) | (x & d);
    endfunction

    initial begin
        void'($urandom(92805));
        wait_cyc(5);
        sys_rst_i <= 1'b0;
        wb(1'b0, IDX_CONFIG, 8'h00); chk(q, RST_CONFIG, "config reset");
        wb(1'b0, IDX_DIRECTION, 8'h00); chk(q, RST_DIRECTION, "dir reset");
        chk(pu, 8'h00, "pullups at reset");
        chk(oe, 8'h00, "drivers at reset");
        wb(1'b0, 8'h40, 8'h00); chk(q, 8'h00, "unmapped read");
        $display("reset test done");
        wb(1'b1, IDX_CONFIG, 8'h7f); ext_en <= 8'h00; wait_cyc(8);
        chk(pu, 8'hff, "pullups on");
        wb(1'b0, IDX_PORT_DATA, 8'h00); chk(q, 8'hff, "pulled-up read");
        wb(1'b1, IDX_DIRECTION, 8'h0f); wait_cyc(2);
        chk(pu, 8'h0f, "pullups off on outputs");
        ext_en <= 8'hff;
        wb(1'b1, IDX_CONFIG, 8'hff);
        $display("pull-up test done");
        for (int i = 0; i < 8; i++) begin
            dir = $urandom; lat = $urandom; v = $urandom; ext_v <= v;
            wb(1'b1, IDX_DIRECTION, dir); wb(1'b1, IDX_PORT_DATA, lat); wait_cyc(8);
            wb(1'b0, IDX_PORT_DATA, 8'h00); chk(q, exp_pins(dir, lat, v), "port read");
            chk(pin_o, lat, "latch");
            chk(oe, ~dir, "drivers");
            chk(pu, 8'h00, "pullups off");
            chk({pdat, pclk, 5'h00, xint}, exp_pins(dir, lat, v) & 8'hc1, "second roles");
        end
        $display("direction test done");
        for (int i = 0; i < 4; i++) begin
            dir = 8'h0f; lat = $urandom; v = $urandom; ext_v <= v; n = $urandom_range(7, 0);
            wb(1'b1, IDX_DIRECTION, dir); wb(1'b1, IDX_PORT_DATA, lat); wait_cyc(8);
            e = exp_pins(dir, lat, v); e[n] = i[0];
            wb(1'b1, IDX_BIT_OP, {i[0], 4'h0, n[2:0]}); wait_cyc(2);
            chk(pin_o, e, "bit operation");
        end
        $display("bit operation test done");
        // Flag reads between the snapshot and the change leave the snapshot alone, so the change still shows.
        v = $urandom; ext_v <= v; wb(1'b1, IDX_DIRECTION, 8'hff); wait_cyc(8);
        wb(1'b0, IDX_PORT_DATA, 8'h00); wb(1'b1, IDX_INT_CTRL, 8'h00);
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h00, "flag after refresh");
        v = v ^ (8'h01 << $urandom_range(3, 0)); ext_v <= v; wait_cyc(8);
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h00, "lower pin change");
        v = v ^ (8'h10 << $urandom_range(3, 0)); ext_v <= v; wait_cyc(8);
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h01, "upper pin change");
        chk({7'h00, wake}, 8'h01, "wake");
        wb(1'b1, IDX_INT_CTRL, 8'h00);
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h01, "clear during mismatch");
        wb(1'b0, IDX_PORT_DATA, 8'h00); wb(1'b1, IDX_INT_CTRL, 8'h00);
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h00, "clear after access");
        $display("change detect test done");
        // With the clock enable low the pin change must not reach any state.
        v = v ^ 8'h11; ext_v <= v; ce_i <= 1'b0; wait_cyc(8);
        chk({7'h00, xint}, {7'h00, ~v[0]}, "frozen while disabled");
        chk({7'h00, wake}, 8'h00, "no wake while disabled");
        ce_i <= 1'b1; wait_cyc(8);
        chk({7'h00, xint}, {7'h00, v[0]}, "second role after enable");
        wb(1'b0, IDX_INT_CTRL, 8'h00); chk(q, 8'h01, "change seen after enable");
        $display("clock enable test done");
        stop_test();
    end
endmodule // port_b_gpio_change_detect_tb
